// *** verilog/mm_timer_defines.svh ***
// Constants for the eight-bit multimode timer: register map, fields, resets, timing.
`ifndef MM_TIMER_DEFINES_SVH
`define MM_TIMER_DEFINES_SVH

`define ADDR_COMPARE      4'h0
`define ADDR_CONTROL      4'h1
`define ADDR_STATUS       4'h2
`define ADDR_MASK         4'h3
`define ADDR_COUNT        4'h4

`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     1
`define CTRL_CLK_LSB      2
`define CTRL_CLK_MSB      4
`define CTRL_RUN_BIT      5
`define CTRL_DIVSTAGE_BIT 6

`define COMPARE_RESET     8'hFF
`define CONTROL_RESET     8'h00
`define MASK_RESET        2'h0
`define COUNT_MAX         8'hFF
`define COUNT_ZERO        8'h00

`define STAT_MATCH_BIT    0
`define STAT_OVF_BIT      1

`define PRESCALE_WIDTH    13
`define EXT_SOURCE        3'h7

`define STATUS_NONE       2'h0
`define DATA_RESET        8'h00

`define PRESC_EXP_SEL0    4'hB
`define PRESC_EXP_SEL1    4'h7
`define PRESC_EXP_SEL2    4'h5
`define PRESC_EXP_SEL3    4'h3
`define PRESC_EXP_SEL4    4'h2
`define PRESC_EXP_SEL5    4'h1
`define PRESC_EXP_FAST    4'h0

`endif

// *** verilog/mm_timer_pkg.sv ***
// Types shared by the eight-bit multimode timer modules.
`default_nettype none
package mm_timer_pkg;
	typedef enum logic [1:0] {
		MODE_TIMER = 2'h0,
		MODE_RSVD  = 2'h1,
		MODE_DIV   = 2'h2,
		MODE_PWM   = 2'h3
	} op_mode_e;
endpackage
`default_nettype wire

// *** verilog/count_tick_if.sv ***
// Count tick bundle between the edge/prescale unit and the timer core.
`default_nettype none
interface count_tick_if;
	logic count_tick;
	logic fall_tick;
	modport source (output count_tick, output fall_tick);
	modport sink   (input count_tick, input fall_tick);
endinterface
`default_nettype wire

// *** verilog/tick_source.sv ***
// Prescaler and external input edge detection that produce count ticks.
`include "mm_timer_defines.svh"
`default_nettype none
module tick_source #(
	parameter int PW = `PRESCALE_WIDTH
) (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       run_control,
	input  wire logic [2:0] source_clock_select,
	input  wire logic       divider_stage_select,
	input  wire logic       external_count_input,
	count_tick_if.source    ticks
);
	logic [PW-1:0] prescale;
	logic          sync_a;
	logic          sync_b;
	logic          sync_c;
	logic [3:0]    tap;
	logic          ext_sel;

	// Free-running prescaler; cleared while stopped so the first period is full.
	always_ff @(posedge ref_clk) begin
		if (reset || !run_control) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	// Two-flop synchroniser; edges are taken only from the second and third flops.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else begin
			sync_a <= external_count_input;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// Divide exponent per select code; the stage bit adds one more halving.
	always_comb begin
		unique case (source_clock_select)
			3'h0:    tap = `PRESC_EXP_SEL0;
			3'h1:    tap = `PRESC_EXP_SEL1;
			3'h2:    tap = `PRESC_EXP_SEL2;
			3'h3:    tap = `PRESC_EXP_SEL3;
			3'h4:    tap = `PRESC_EXP_SEL4;
			3'h5:    tap = `PRESC_EXP_SEL5;
			default: tap = `PRESC_EXP_FAST;
		endcase
		tap = tap + {3'h0, divider_stage_select};
	end

	assign ext_sel = (source_clock_select == `EXT_SOURCE);

	// A tick is one cycle where all low bits below the tap are ones.
	always_comb begin
		logic [PW-1:0] m;
		m = '0;
		m = (PW'(1) << tap) - PW'(1);
		if (ext_sel) begin
			ticks.count_tick = run_control && sync_b && !sync_c;
			ticks.fall_tick  = run_control && !sync_b && sync_c;
		end else begin
			ticks.count_tick = run_control && ((prescale & m) == m);
			ticks.fall_tick  = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** verilog/eight_bit_multimode_timer.sv ***
// Eight-bit multimode timer with Wishbone register access and interrupt output.
// Operation
// - Timer mode counts prescaled ticks; match raises interrupt, clears, continues.
// - Event mode counts rising edges of the external input.
// - Event mode checks match on the falling edge after reaching compare.
// - Divider mode toggles output on match, interrupts, clears, continues.
// - Divider output is high while stopped.
// - PWM output goes low on match, high and interrupt on overflow.
// - PWM output is high while stopped.
// - PWM compare writes take effect only at end of cycle.
// - Starting the timer loads the written compare value.
// - Mode field: 00 timer/event, 10 divider, 11 PWM, 01 reserved.
// - Run bit one counts; zero stops and clears the counter.
// - Entering stop state clears the run bit.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`include "mm_timer_defines.svh"
`default_nettype none
module eight_bit_multimode_timer (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic [3:0] wb_adr_i,
	input  wire logic [7:0] wb_dat_i,
	output logic      [7:0] wb_dat_o,
	input  wire logic       wb_we_i,
	input  wire logic       wb_sel_i,
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	output logic            wb_ack_o,
	input  wire logic       stop_entry,
	input  wire logic       external_count_input,
	output logic            divider_output_pin,
	output logic            pwm_output_pin_n,
	output logic            match_irq
);
	logic [7:0] compare_value_reg;
	logic [7:0] active_compare;
	logic [7:0] timer_control_reg;
	logic [7:0] count;
	logic [1:0] status;
	logic [1:0] mask;
	logic       run_d;
	logic       match_ev;
	logic       ovf_ev;
	logic       wr_stb;
	logic       rd_stb;
	logic       run_control;
	logic [2:0] source_clock_select;
	logic       divider_stage_select;
	mm_timer_pkg::op_mode_e operating_mode_select;
	logic [7:0] next_count;

	count_tick_if tk ();

	assign run_control          = timer_control_reg[`CTRL_RUN_BIT];
	assign source_clock_select  = timer_control_reg[`CTRL_CLK_MSB:`CTRL_CLK_LSB];
	assign divider_stage_select = timer_control_reg[`CTRL_DIVSTAGE_BIT];
	assign operating_mode_select =
		mm_timer_pkg::op_mode_e'(timer_control_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);

	tick_source u_ticks (
		.ref_clk              (ref_clk),
		.reset                (reset),
		.run_control          (run_control),
		.source_clock_select  (source_clock_select),
		.divider_stage_select (divider_stage_select),
		.external_count_input (external_count_input),
		.ticks                (tk.source)
	);

	// Bus strobes: a new access is taken only when ack is low, giving one wait state.
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i;
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	// Single-cycle ack, dropped the cycle after it is given.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Read mux; unmapped addresses read zero. Status read clears below.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wb_dat_o <= `DATA_RESET;
		end else if (rd_stb) begin
			unique case (wb_adr_i)
				`ADDR_COMPARE: wb_dat_o <= compare_value_reg;
				`ADDR_CONTROL: wb_dat_o <= {2'h0, timer_control_reg[`CTRL_RUN_BIT:0]};
				`ADDR_STATUS:  wb_dat_o <= {6'h00, status};
				`ADDR_MASK:    wb_dat_o <= {6'h00, mask};
				`ADDR_COUNT:   wb_dat_o <= count;
				default:       wb_dat_o <= 8'h00;
			endcase
		end
	end

	// Compare buffer register as seen by software.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			compare_value_reg <= `COMPARE_RESET;
		end else if (wr_stb && wb_adr_i == `ADDR_COMPARE) begin
			compare_value_reg <= wb_dat_i;
		end
	end

	// Control register; stop entry forces the run bit low and wins over a write.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			timer_control_reg <= `CONTROL_RESET;
		end else begin
			if (wr_stb && wb_adr_i == `ADDR_CONTROL) begin
				timer_control_reg <= wb_dat_i;
			end
			if (stop_entry) begin
				timer_control_reg[`CTRL_RUN_BIT] <= 1'b0;
			end
		end
	end

	// Interrupt mask register.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mask <= `MASK_RESET;
		end else if (wr_stb && wb_adr_i == `ADDR_MASK) begin
			mask <= wb_dat_i[1:0];
		end
	end

	// Run bit history, used to catch the start moment.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run_d <= 1'b0;
		end else begin
			run_d <= run_control;
		end
	end

	// Active compare stage. Outside PWM it follows the buffer directly; in PWM it
	// only updates at start or at the overflow ending a cycle, so a glitch-free
	// duty change needs no software timing beyond writing after the interrupt.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			active_compare <= `COMPARE_RESET;
		end else if (run_control && !run_d) begin
			active_compare <= compare_value_reg;
		end else if (operating_mode_select != mm_timer_pkg::MODE_PWM) begin
			active_compare <= compare_value_reg;
		end else if (ovf_ev) begin
			active_compare <= compare_value_reg;
		end
	end

	// Match and overflow events per mode.
	always_comb begin
		match_ev = 1'b0;
		ovf_ev   = 1'b0;
		unique case (operating_mode_select)
			mm_timer_pkg::MODE_TIMER: begin
				if (source_clock_select == `EXT_SOURCE) begin
					match_ev = tk.fall_tick && (count == active_compare);
				end else begin
					match_ev = tk.count_tick && (count == active_compare);
				end
			end
			mm_timer_pkg::MODE_DIV: begin
				match_ev = tk.count_tick && (count == active_compare);
			end
			mm_timer_pkg::MODE_PWM: begin
				match_ev = tk.count_tick && (count == active_compare);
				ovf_ev   = tk.count_tick && (count == `COUNT_MAX);
			end
			default: begin
				match_ev = 1'b0;
			end
		endcase
	end

	// Counter next value: match clears in non-PWM modes, PWM wraps on overflow.
	always_comb begin
		next_count = count;
		if (!run_control) begin
			next_count = `COUNT_ZERO;
		end else if (match_ev && operating_mode_select != mm_timer_pkg::MODE_PWM) begin
			next_count = `COUNT_ZERO;
		end else if (tk.count_tick && operating_mode_select != mm_timer_pkg::MODE_RSVD) begin
			next_count = count + 8'h01;
		end
	end

	// Up-counter.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count <= `COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	// Divider output: toggles on match, high while stopped.
	always_ff @(posedge ref_clk) begin
		if (reset || !run_control) begin
			divider_output_pin <= 1'b1;
		end else if (match_ev && operating_mode_select == mm_timer_pkg::MODE_DIV) begin
			divider_output_pin <= !divider_output_pin;
		end
	end

	// PWM output, active low: overflow takes priority so compare FF never sticks low.
	always_ff @(posedge ref_clk) begin
		if (reset || !run_control || operating_mode_select != mm_timer_pkg::MODE_PWM) begin
			pwm_output_pin_n <= 1'b1;
		end else if (ovf_ev) begin
			pwm_output_pin_n <= 1'b1;
		end else if (match_ev) begin
			pwm_output_pin_n <= 1'b0;
		end
	end

	// Sticky status; an event in the clearing cycle survives the read.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status <= `STATUS_NONE;
		end else begin
			if (rd_stb && wb_adr_i == `ADDR_STATUS) begin
				status <= `STATUS_NONE;
			end
			if (match_ev && operating_mode_select != mm_timer_pkg::MODE_PWM) begin
				status[`STAT_MATCH_BIT] <= 1'b1;
			end
			if (ovf_ev) begin
				status[`STAT_OVF_BIT] <= 1'b1;
			end
		end
	end

	// Level interrupt output.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			match_irq <= 1'b0;
		end else begin
			match_irq <= |(status & mask);
		end
	end

	AST_STOP_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
		!run_control |=> count == `COUNT_ZERO)
		else $error("Counter not cleared while stopped.");
	AST_DIV_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
		!run_control |=> divider_output_pin)
		else $error("Divider output low while stopped.");
	AST_PWM_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
		!run_control |=> pwm_output_pin_n)
		else $error("PWM output low while stopped.");
	AST_DIV_TOGGLE: assert property (@(posedge ref_clk) disable iff (reset)
		(run_control && match_ev && operating_mode_select == mm_timer_pkg::MODE_DIV
		&& !stop_entry && !(wr_stb && wb_adr_i == `ADDR_CONTROL))
		|=> divider_output_pin != $past(divider_output_pin))
		else $error("Divider output did not toggle on match.");
	AST_MATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
		(match_ev && operating_mode_select != mm_timer_pkg::MODE_PWM)
		|=> count == `COUNT_ZERO)
		else $error("Counter not cleared on match.");
	AST_MATCH_STATUS: assert property (@(posedge ref_clk) disable iff (reset)
		(match_ev && operating_mode_select != mm_timer_pkg::MODE_PWM)
		|=> status[`STAT_MATCH_BIT])
		else $error("Match event not recorded.");
	AST_PWM_LOW: assert property (@(posedge ref_clk) disable iff (reset)
		(run_control && match_ev && !ovf_ev && operating_mode_select == mm_timer_pkg::MODE_PWM
		&& !stop_entry && !(wr_stb && wb_adr_i == `ADDR_CONTROL))
		|=> !pwm_output_pin_n)
		else $error("PWM output not low after match.");
	AST_PWM_RELOAD: assert property (@(posedge ref_clk) disable iff (reset)
		(run_d && operating_mode_select == mm_timer_pkg::MODE_PWM && !ovf_ev
		&& !$stable(compare_value_reg)) |-> $stable(active_compare))
		else $error("PWM compare changed mid cycle.");
	AST_START_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
		(run_control && !run_d) |=> active_compare == $past(compare_value_reg))
		else $error("Compare not loaded at start.");
	AST_STOP_ENTRY: assert property (@(posedge ref_clk) disable iff (reset)
		stop_entry |=> !run_control)
		else $error("Stop entry did not clear run bit.");
	AST_EXT_COUNT: assert property (@(posedge ref_clk) disable iff (reset)
		(tk.count_tick && run_control && !match_ev && operating_mode_select ==
		mm_timer_pkg::MODE_TIMER && !stop_entry && !(wr_stb && wb_adr_i == `ADDR_CONTROL))
		|=> count == $past(count) + 8'h01)
		else $error("Counter did not advance on tick.");
endmodule
`default_nettype wire

// *** verification/event_source.sv ***
// Behavioural source for the external count input of the timer.
`default_nettype none
module event_source (
	input  wire logic ref_clk,
	output logic      external_count_input
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 47892;

	// The input idles low until a scenario asks for an edge.
	initial external_count_input = 1'b0;

	// Each phase is held 8 to 11 clocks so no edge can be lost by the sampler.
	task automatic drive_phase(input logic lvl);
		int n;
		n = 8 + ($random(seed) & 3);
		@(posedge ref_clk);
		external_count_input <= lvl;
		repeat (n) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// *** verification/eight_bit_multimode_timer_tb.sv ***
// Self-checking bench for the eight-bit multimode timer.
`default_nettype none
module eight_bit_multimode_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk = 1'b0;
	logic       reset = 1'b1;
	logic [3:0] wb_adr_i = 4'h0;
	logic [7:0] wb_dat_i = 8'h00;
	logic [7:0] wb_dat_o;
	logic       wb_we_i = 1'b0;
	logic       wb_sel_i = 1'b0;
	logic       wb_cyc_i = 1'b0;
	logic       wb_stb_i = 1'b0;
	logic       wb_ack_o;
	logic       stop_entry = 1'b0;
	wire logic  external_count_input;
	logic       divider_output_pin;
	logic       pwm_output_pin_n;
	logic       match_irq;
	int         seed = 47892;
	int         miscompares = 0;
	int         comparisons = 0;
	int         exp_w[$];
	int         w;
	logic [7:0] q;
	logic [7:0] cmp;
	logic [7:0] rst_tab [6] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// Free-running 10 MHz clock.
	always #50 ref_clk = ~ref_clk;

	eight_bit_multimode_timer eight_bit_multimode_timer_inst (
		.ref_clk(ref_clk), .reset(reset), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .stop_entry(stop_entry),
		.external_count_input(external_count_input),
		.divider_output_pin(divider_output_pin), .pwm_output_pin_n(pwm_output_pin_n),
		.match_irq(match_irq)
	);

	event_source event_source_inst (
		.ref_clk(ref_clk),
		.external_count_input(external_count_input)
	);

	// Single exit point of the run.
	task automatic give_verdict;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb_cycle(input logic [3:0] a, input logic we, input logic [7:0] d);
		int n;
		n = 0;
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= 1'b1;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			give_verdict();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		wb_cycle(a, 1'b0, 8'h00);
		check(q, exp);
	endtask

	function automatic logic pin(input int sel);
		return (sel == 0) ? divider_output_pin : pwm_output_pin_n;
	endfunction

	// Counts edges until the chosen pin shows the level; both ends share one latency.
	task automatic wait_pin(input int sel, input logic lvl, output int cyc);
		cyc = 0;
		while (pin(sel) !== lvl) begin
			@(posedge ref_clk);
			cyc++;
			if (cyc > 3000) begin
				miscompares++;
				give_verdict();
			end
		end
	endtask

	// Guards against a hang anywhere in the sequence.
	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		give_verdict();
	end

	// Main sequence: reset values, divider, timer, reserved mode, events, PWM.
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		check(divider_output_pin, 1'b1);
		check(pwm_output_pin_n, 1'b1);
		for (int i = 0; i < 6; i++) rd_chk(4'(i), rst_tab[i]);
		wb_cycle(4'h1, 1'b1, 8'hB4);
		rd_chk(4'h1, 8'h34);
		wb_cycle(4'h1, 1'b1, 8'h14);
		// Divider with the extra stage: half period is compare plus one ticks of four clocks.
		cmp = 8'h01 + 8'($random(seed) & 32'h0F);
		wb_cycle(4'h0, 1'b1, cmp);
		wb_cycle(4'h3, 1'b1, 8'h01);
		wb_cycle(4'h1, 1'b1, 8'h76);
		wait_pin(0, 1'b0, w);
		wait_pin(0, 1'b1, w);
		check(16'(w), 16'(4 * (cmp + 1)));
		repeat (3) @(posedge ref_clk);
		check(match_irq, 1'b1);
		wb_cycle(4'h1, 1'b1, 8'h16);
		repeat (2) @(posedge ref_clk);
		check(divider_output_pin, 1'b1);
		rd_chk(4'h4, 8'h00);
		rd_chk(4'h2, 8'h01);
		rd_chk(4'h2, 8'h00);
		repeat (3) @(posedge ref_clk);
		check(match_irq, 1'b0);
		// Timer mode with the match masked: status sets, the line stays low.
		wb_cycle(4'h3, 1'b1, 8'h00);
		wb_cycle(4'h1, 1'b1, 8'h34);
		repeat (4 * (cmp + 1) + 8) @(posedge ref_clk);
		check(match_irq, 1'b0);
		wb_cycle(4'h1, 1'b1, 8'h14);
		rd_chk(4'h2, 8'h01);
		wb_cycle(4'h1, 1'b1, 8'h35);
		repeat (20) @(posedge ref_clk);
		rd_chk(4'h4, 8'h00);
		wb_cycle(4'h1, 1'b1, 8'h15);
		// Event mode: match waits for the falling edge after the third rise.
		wb_cycle(4'h0, 1'b1, 8'h03);
		wb_cycle(4'h3, 1'b1, 8'h01);
		wb_cycle(4'h1, 1'b1, 8'h3C);
		repeat (2) begin
			event_source_inst.drive_phase(1'b1);
			event_source_inst.drive_phase(1'b0);
		end
		rd_chk(4'h4, 8'h02);
		event_source_inst.drive_phase(1'b1);
		rd_chk(4'h4, 8'h03);
		check(match_irq, 1'b0);
		event_source_inst.drive_phase(1'b0);
		rd_chk(4'h2, 8'h01);
		rd_chk(4'h4, 8'h00);
		@(posedge ref_clk);
		stop_entry <= 1'b1;
		@(posedge ref_clk);
		stop_entry <= 1'b0;
		rd_chk(4'h1, 8'h1C);
		rd_chk(4'h4, 8'h00);
		// PWM: the low phase spans the ticks from the match count to the overflow count,
		// so it lasts 255 minus compare ticks; a new compare waits a cycle.
		cmp = 8'h10 + 8'($random(seed) & 32'h7F);
		wb_cycle(4'h0, 1'b1, cmp);
		wb_cycle(4'h3, 1'b1, 8'h02);
		wb_cycle(4'h1, 1'b1, 8'h37);
		exp_w.push_back(2 * (255 - cmp));
		exp_w.push_back(2 * (255 - cmp));
		wait_pin(1, 1'b0, w);
		wait_pin(1, 1'b1, w);
		check(16'(w), 16'(exp_w.pop_front()));
		cmp = 8'h10 + 8'($random(seed) & 32'h7F);
		exp_w.push_back(2 * (255 - cmp));
		wb_cycle(4'h0, 1'b1, cmp);
		check(match_irq, 1'b1);
		repeat (2) begin
			wait_pin(1, 1'b0, w);
			wait_pin(1, 1'b1, w);
			check(16'(w), 16'(exp_w.pop_front()));
		end
		wb_cycle(4'h2, 1'b0, 8'h00);
		check(q, 8'h02);
		wb_cycle(4'h1, 1'b1, 8'h17);
		repeat (2) @(posedge ref_clk);
		check(pwm_output_pin_n, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
